// >>> oad_addr_engine.v
// operand address engine: apb register file, eight general registers and
// the sequencer that forms source and destination operand addresses
// assumes a memory read port that answers with mem_rd_ack after any delay
`default_nettype none

module oad_addr_engine (
    // clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // operand memory read path
    output reg         mem_rd_req,
    output reg  [15:0] mem_addr,
    input  wire [15:0] mem_rdata,
    input  wire        mem_rd_ack,
    // status
    output wire        busy,
    output reg         done
);
`include "oad_map.vh"

    // ======================================================================
    // states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SPEC = 3'h1;
    localparam [2:0] ST_EXT  = 3'h2;
    localparam [2:0] ST_PTR  = 3'h3;
    localparam [2:0] ST_FIN  = 3'h4;

    // ======================================================================
    // storage
    reg  [15:0] gpr_q [0:7];
    reg  [15:0] instr_q;
    reg  [2:0]  state_q;
    reg         phase_dst_q;
    reg         bad_q;
    reg  [1:0]  words_q;
    reg  [15:0] ea_q;
    reg         ea_reg_q;
    reg  [15:0] src_ea_q;
    reg         src_reg_q;
    reg  [15:0] dst_ea_q;
    reg         dst_reg_q;

    // ======================================================================
    // decoders
    wire [2:0]  op;
    wire        double_op;
    wire        byte_op;
    wire        legal;
    wire [2:0]  s_mode;
    wire [2:0]  s_rsel;
    wire        s_def;
    wire        s_pc;
    wire [15:0] s_step;
    wire [2:0]  d_mode;
    wire [2:0]  d_rsel;
    wire        d_def;
    wire        d_pc;
    wire [15:0] d_step;

    oad_op_dec u_op (
        .instr     (instr_q),
        .op        (op),
        .double_op (double_op),
        .byte_op   (byte_op),
        .legal     (legal)
    );

    oad_spec_dec u_src (
        .spec     (instr_q[`OAD_SRC_HI:`OAD_SRC_LO]),
        .byte_op  (byte_op),
        .mode     (s_mode),
        .rsel     (s_rsel),
        .deferred (s_def),
        .is_pc    (s_pc),
        .step     (s_step)
    );

    oad_spec_dec u_dst (
        .spec     (instr_q[`OAD_DST_HI:`OAD_DST_LO]),
        .byte_op  (byte_op),
        .mode     (d_mode),
        .rsel     (d_rsel),
        .deferred (d_def),
        .is_pc    (d_pc),
        .step     (d_step)
    );

    // ======================================================================
    // current specifier, chosen by phase
    wire [2:0]  c_mode = phase_dst_q ? d_mode : s_mode;
    wire [2:0]  c_rsel = phase_dst_q ? d_rsel : s_rsel;
    wire        c_def  = phase_dst_q ? d_def  : s_def;
    wire        c_pc   = phase_dst_q ? d_pc   : s_pc;
    wire [15:0] c_step = phase_dst_q ? d_step : s_step;
    wire [15:0] c_reg  = gpr_q[c_rsel];
    wire [15:0] pc_val = gpr_q[`OAD_PC_REG];

    // ======================================================================
    // apb decode
    wire setup   = psel && !penable;
    wire access  = psel && penable;
    wire is_gpr  = (paddr >= `OAD_GPR_BASE_OFS) && (paddr <= `OAD_GPR_TOP_OFS);
    wire aligned = (paddr[1:0] == 2'h0);
    wire mapped  = aligned && (is_gpr
                   || paddr == `OAD_CTRL_OFS   || paddr == `OAD_INSTR_OFS
                   || paddr == `OAD_STATUS_OFS || paddr == `OAD_SRC_EA_OFS
                   || paddr == `OAD_DST_EA_OFS || paddr == `OAD_OPINFO_OFS);
    wire [2:0] gidx = paddr[4:2];
    // a frozen block cannot complete a transfer
    assign pready  = ce;
    assign pslverr = access && !mapped;
    wire wr_ok     = ce && access && pwrite && mapped;
    wire idle      = (state_q == ST_IDLE);
    // instruction and registers are refused while a decode runs
    wire wr_gpr    = wr_ok && is_gpr && idle;
    wire wr_instr  = wr_ok && paddr == `OAD_INSTR_OFS && idle;
    wire start     = wr_ok && paddr == `OAD_CTRL_OFS && idle
                     && pwdata[`OAD_CTRL_START_BIT];
    wire clr_done  = wr_ok && paddr == `OAD_STATUS_OFS
                     && pwdata[`OAD_STAT_DONE_BIT];
    assign busy    = !idle;

    // ======================================================================
    // read mux, captured in the setup cycle
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `OAD_INSTR_OFS:  rd_d = {16'h0000, instr_q};
            `OAD_STATUS_OFS: rd_d = {22'h000000, words_q, 5'h00, bad_q,
                                     done, busy};
            `OAD_SRC_EA_OFS: rd_d = {15'h0000, src_reg_q, src_ea_q};
            `OAD_DST_EA_OFS: rd_d = {15'h0000, dst_reg_q, dst_ea_q};
            `OAD_OPINFO_OFS: rd_d = {12'h000, s_mode, s_rsel, d_mode, d_rsel,
                                     2'h0, double_op, byte_op, 1'b0, op};
            default: begin
                if (is_gpr && aligned) begin
                    rd_d = {16'h0000, gpr_q[gidx]};
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setup && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // ======================================================================
    // sequencer and general registers
    integer i;
    wire [15:0] ext_sum = mem_rdata + c_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                gpr_q[i] <= `OAD_GPR_RST;
            end
            instr_q     <= `OAD_INSTR_RST;
            state_q     <= ST_IDLE;
            phase_dst_q <= 1'b0;
            bad_q       <= 1'b0;
            done        <= 1'b0;
            words_q     <= 2'h0;
            ea_q        <= 16'h0000;
            ea_reg_q    <= 1'b0;
            src_ea_q    <= 16'h0000;
            src_reg_q   <= 1'b0;
            dst_ea_q    <= 16'h0000;
            dst_reg_q   <= 1'b0;
            mem_rd_req  <= 1'b0;
            mem_addr    <= 16'h0000;
        end else if (ce) begin
            if (wr_gpr) begin
                gpr_q[gidx] <= pwdata[15:0];
            end
            if (wr_instr) begin
                instr_q <= pwdata[15:0];
            end
            // sticky done: a completion in the clear cycle wins
            if (clr_done) begin
                done <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        words_q   <= 2'h1;
                        src_reg_q <= 1'b0;
                        src_ea_q  <= 16'h0000;
                        if (!legal) begin
                            bad_q <= 1'b1;
                            done  <= 1'b1;
                        end else begin
                            bad_q       <= 1'b0;
                            phase_dst_q <= !double_op;
                            state_q     <= ST_SPEC;
                        end
                    end
                end
                ST_SPEC: begin
                    ea_reg_q <= 1'b0;
                    state_q  <= ST_FIN;
                    case (c_mode)
                        3'h0: begin
                            ea_q     <= {13'h0000, c_rsel};
                            ea_reg_q <= 1'b1;
                        end
                        3'h1: begin
                            ea_q <= c_reg;
                        end
                        3'h2: begin
                            ea_q <= c_reg;
                            gpr_q[c_rsel] <= c_reg + c_step;
                            if (c_pc) begin
                                words_q <= words_q + 2'h1;
                            end
                        end
                        3'h3: begin
                            mem_addr      <= c_reg;
                            mem_rd_req    <= 1'b1;
                            gpr_q[c_rsel] <= c_reg + `OAD_WORD_STEP;
                            state_q       <= ST_PTR;
                            if (c_pc) begin
                                words_q <= words_q + 2'h1;
                            end
                        end
                        3'h4: begin
                            ea_q          <= c_reg - c_step;
                            gpr_q[c_rsel] <= c_reg - c_step;
                        end
                        3'h5: begin
                            mem_addr      <= c_reg - `OAD_WORD_STEP;
                            mem_rd_req    <= 1'b1;
                            gpr_q[c_rsel] <= c_reg - `OAD_WORD_STEP;
                            state_q       <= ST_PTR;
                        end
                        default: begin
                            // modes 6 and 7: extension word at the counter
                            mem_addr   <= pc_val;
                            mem_rd_req <= 1'b1;
                            gpr_q[`OAD_PC_REG] <= pc_val + `OAD_WORD_STEP;
                            words_q    <= words_q + 2'h1;
                            state_q    <= ST_EXT;
                        end
                    endcase
                end
                ST_EXT: begin
                    // counter already stepped, so relative uses updated value
                    if (mem_rd_ack) begin
                        if (c_def) begin
                            mem_addr <= ext_sum;
                            state_q  <= ST_PTR;
                        end else begin
                            mem_rd_req <= 1'b0;
                            ea_q       <= ext_sum;
                            state_q    <= ST_FIN;
                        end
                    end
                end
                ST_PTR: begin
                    if (mem_rd_ack) begin
                        mem_rd_req <= 1'b0;
                        ea_q       <= mem_rdata;
                        state_q    <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    if (phase_dst_q) begin
                        dst_ea_q  <= ea_q;
                        dst_reg_q <= ea_reg_q;
                        done      <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else begin
                        src_ea_q    <= ea_q;
                        src_reg_q   <= ea_reg_q;
                        phase_dst_q <= 1'b1;
                        state_q     <= ST_SPEC;
                    end
                end
                default: begin
                    state_q    <= ST_IDLE;
                    mem_rd_req <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // note: stack pointer keeps no special step here; it behaves like the
    // general registers, only the counter is forced to whole words

endmodule // oad_addr_engine

`default_nettype wire

// >>> oad_map.vh
// constants for the operand address mode decoder: apb offsets, fields,
// opcode patterns and reset values
// assumes a 16-bit instruction word and an apb bus with 32-bit data
//
// Overview of operation
// - all operand addressing goes through eight general registers chosen by specifier
// - register 6 is the stack pointer; registers 0 to 5 are general
// - register 7 is the program counter used for instruction fetches
// - addressing mode comes from specifier bits 5 to 3
// - low mode bit set adds one level of indirection (deferred form)
// - destination specifier is six bits of mode and register
// - double-operand words also carry a six-bit source specifier
// - 0050DD zeroes destination word, 1050DD zeroes destination byte
// - 0052DD adds one to destination word, 1052DD to destination byte
// - 0051DD inverts destination word, 1051DD inverts destination byte
// - 06SSDD adds source to destination, result written to destination
// - mode 0 takes operand from register, no memory reference
// - mode 1 uses register contents as operand address
// - mode 2 uses register as address, then adds 1 (byte) or 2
// - mode 3 fetches address via register, then adds 2 to register
// - mode 4 first subtracts 1 (byte) or 2, then uses new value
// - instructions are one, two or three words long
// - index register contents plus following extension word form the address
// - mode 5 subtracts 2, result addresses the operand address
// - mode 6 adds the next extension word to the register
// - mode 7 register plus extension word addresses a pointer to operand
// - program counter always steps by 2, even for byte operations
`ifndef OAD_MAP_VH
`define OAD_MAP_VH

// ==========================================================================
// apb register offsets
`define OAD_CTRL_OFS      8'h00
`define OAD_INSTR_OFS     8'h04
`define OAD_STATUS_OFS    8'h08
`define OAD_SRC_EA_OFS    8'h0C
`define OAD_DST_EA_OFS    8'h10
`define OAD_OPINFO_OFS    8'h14
`define OAD_GPR_BASE_OFS  8'h20
`define OAD_GPR_TOP_OFS   8'h3C

// ==========================================================================
// register fields
`define OAD_CTRL_START_BIT   0
`define OAD_STAT_BUSY_BIT    0
`define OAD_STAT_DONE_BIT    1
`define OAD_STAT_BAD_BIT     2
`define OAD_EA_ISREG_BIT     16
`define OAD_INSTR_RST        16'h0000
`define OAD_GPR_RST          16'h0000

// ==========================================================================
// specifier layout
`define OAD_SPEC_MODE_HI  5
`define OAD_SPEC_MODE_LO  3
`define OAD_SPEC_REG_HI   2
`define OAD_SPEC_REG_LO   0
`define OAD_SRC_HI        11
`define OAD_SRC_LO        6
`define OAD_DST_HI        5
`define OAD_DST_LO        0
`define OAD_BYTE_BIT      15
`define OAD_STACK_REG     3'h6
`define OAD_PC_REG        3'h7
`define OAD_WORD_STEP     16'h0002
`define OAD_BYTE_STEP     16'h0001

// ==========================================================================
// opcode patterns, instruction bits 14 to 6 (add: bits 14 to 12), and operation codes
`define OAD_PAT_ZERO      9'h028
`define OAD_PAT_INV       9'h029
`define OAD_PAT_PLUS      9'h02A
`define OAD_PAT_ADD       3'h6
`define OAD_OP_NONE       3'h0
`define OAD_OP_ZERO       3'h1
`define OAD_OP_INV        3'h2
`define OAD_OP_PLUS       3'h3
`define OAD_OP_ADD        3'h4

`endif

// >>> oad_spec_dec.v
// splits one six-bit operand specifier into mode, register and step
// assumes the caller supplies the byte width of the current operation
`default_nettype none

module oad_spec_dec (
    // specifier in
    input  wire [5:0]  spec,
    input  wire        byte_op,
    // decoded fields
    output wire [2:0]  mode,
    output wire [2:0]  rsel,
    output wire        deferred,
    output wire        is_pc,
    output wire [15:0] step
);
`include "oad_map.vh"

    // ======================================================================
    // field split
    assign mode     = spec[`OAD_SPEC_MODE_HI:`OAD_SPEC_MODE_LO];
    assign rsel     = spec[`OAD_SPEC_REG_HI:`OAD_SPEC_REG_LO];
    assign deferred = mode[0];
    assign is_pc    = (rsel == `OAD_PC_REG);
    // stepping the counter by one would leave it on an odd fetch address
    assign step = (byte_op && !is_pc) ? `OAD_BYTE_STEP
                                      : `OAD_WORD_STEP;

endmodule // oad_spec_dec

`default_nettype wire

// >>> oad_op_dec.v
// recognises the operations this decoder understands from an instruction
// assumes a full 16-bit instruction word, octal pattern matching
`default_nettype none

module oad_op_dec (
    // instruction in
    input  wire [15:0] instr,
    // decoded operation
    output reg  [2:0]  op,
    output wire        double_op,
    output wire        byte_op,
    output wire        legal
);
`include "oad_map.vh"

    // ======================================================================
    // opcode match
    assign double_op = (instr[15:12] == {1'b0, `OAD_PAT_ADD});
    always @* begin
        op = `OAD_OP_NONE;
        if (double_op) begin
            op = `OAD_OP_ADD;
        end else begin
            case (instr[14:6])
                `OAD_PAT_ZERO: op = `OAD_OP_ZERO;
                `OAD_PAT_INV:  op = `OAD_OP_INV;
                `OAD_PAT_PLUS: op = `OAD_OP_PLUS;
                default:       op = `OAD_OP_NONE;
            endcase
        end
    end
    assign legal   = (op != `OAD_OP_NONE);
    // add is always a word operation
    assign byte_op = !double_op && instr[`OAD_BYTE_BIT];

endmodule // oad_op_dec

`default_nettype wire

// >>> oad_monitor.sv
// checker for the operand address engine, bound to its ports
// assumes oad_map.vh offsets and one pclk domain
`include "oad_map.vh"
`default_nettype none

module oad_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // memory and status
    input wire logic        mem_rd_req,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_rdata,
    input wire logic        mem_rd_ack,
    input wire logic        busy,
    input wire logic        done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;

    // ==========================================================
    // sequences
    sequence stat_rd_s;
        psel && !penable && !pwrite && paddr == `OAD_STATUS_OFS && ce;
    endsequence
    sequence start_s;
        acc && pwrite && pready && paddr == `OAD_CTRL_OFS && pwdata[0]
            && !busy;
    endsequence

    // ==========================================================
    // properties
    pready_a: assert property (pready == ce)
        else $error("pready differs from ce");
    start_a: assert property (start_s |=> busy || done)
        else $error("start did not begin a decode");
    stat_rd_a: assert property (stat_rd_s |=>
        prdata[1:0] == $past({done, busy}))
        else $error("status read shows stale flags");
    req_busy_a: assert property (mem_rd_req |-> busy)
        else $error("memory read outside a decode");
    req_hold_a: assert property (mem_rd_req && !mem_rd_ack |=>
        mem_rd_req && $stable(mem_addr))
        else $error("read request dropped before answer");
    busy_end_a: assert property ($rose(busy) |->
        ##[1:300] !busy)
        else $error("decode never finished");
    done_hold_a: assert property (done && !(psel && pwrite) |=>
        done)
        else $error("done fell without a write");
    gpr_hi_a: assert property (acc && !pwrite &&
        paddr[7:5] == 3'h1 |-> prdata[31:16] == 16'h0000)
        else $error("register read has upper bits set");
    unmap_a: assert property (acc && paddr >= 8'h40 |-> pslverr)
        else $error("unmapped access without error");
    err_phase_a: assert property (pslverr |-> acc)
        else $error("error outside access phase");
endmodule // oad_monitor

bind oad_addr_engine oad_monitor mon (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rd_ack(mem_rd_ack), .busy(busy),
    .done(done));
`default_nettype wire

// >>> oad_mem_model.sv
// operand memory model answering the engine's reads
// assumes one pclk domain; each word read is the inverted address
`default_nettype none

module oad_mem_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // wait cycles before each answer
    input  wire logic [7:0]  lat,
    // read path
    input  wire logic        mem_rd_req,
    input  wire logic [15:0] mem_addr,
    output var  logic [15:0] mem_rdata,
    output var  logic        mem_rd_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q;

    // ==========================================================
    // answer logic
    // data toggles between answers so a stale sample never matches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q     <= 8'h00;
            mem_rd_ack <= 1'b0;
            mem_rdata  <= 16'h0000;
        end else if (!mem_rd_ack && mem_rd_req && wait_q >= lat) begin
            mem_rd_ack <= 1'b1;
            mem_rdata  <= ~mem_addr;
            wait_q     <= 8'h00;
        end else begin
            mem_rd_ack <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            wait_q     <= (mem_rd_req && !mem_rd_ack) ? wait_q + 8'h01
                                                      : 8'h00;
        end
    end
endmodule // oad_mem_model
`default_nettype wire

// >>> tb_top.sv
// testbench for the operand address engine over apb
// assumes oad_map.vh offsets and the memory model's inverted data
`include "oad_map.vh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] ins;
        logic [2:0]  rn;
        logic [15:0] raft;
        logic [16:0] dea;
        logic [16:0] sea;
        logic [1:0]  rds;
        logic [1:0]  wc;
        logic [5:0]  opi;
    } oad_case_t;
    logic        pclk, presetn, ce, psel, penable, pwrite, err;
    logic        pready, pslverr, mem_rd_req, mem_rd_ack, busy, done;
    logic [7:0]  paddr, lat;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mem_addr, mem_rdata;
    int          n_reads, base, cyc, n_errors, checked;
    oad_case_t   c;
    oad_case_t   tbl [13] = '{
        '{16'h0A83, 3'h3, 16'h1000, 17'h10003, 17'h0, 2'h0, 2'h1, 6'h03},
        '{16'h0A0D, 3'h5, 16'h1000, 17'h01000, 17'h0, 2'h0, 2'h1, 6'h01},
        '{16'h8A15, 3'h5, 16'h1001, 17'h01000, 17'h0, 2'h0, 2'h1, 6'h11},
        '{16'h0A15, 3'h5, 16'h1002, 17'h01000, 17'h0, 2'h0, 2'h1, 6'h01},
        '{16'h0A9A, 3'h2, 16'h1002, 17'h0EFFF, 17'h0, 2'h1, 2'h1, 6'h03},
        '{16'h8AA0, 3'h0, 16'h0FFF, 17'h00FFF, 17'h0, 2'h0, 2'h1, 6'h13},
        '{16'h0A60, 3'h0, 16'h0FFE, 17'h00FFE, 17'h0, 2'h0, 2'h1, 6'h02},
        '{16'h8A68, 3'h0, 16'h0FFE, 17'h0F001, 17'h0, 2'h1, 2'h1, 6'h12},
        '{16'h0A34, 3'h4, 16'h1000, 17'h00DFF, 17'h0, 2'h1, 2'h2, 6'h01},
        '{16'h0A3C, 3'h4, 16'h1000, 17'h0F200, 17'h0, 2'h2, 2'h2, 6'h01},
        '{16'h8A17, 3'h7, 16'h0202, 17'h00200, 17'h0, 2'h0, 2'h2, 6'h11},
        '{16'h6E81, 3'h2, 16'h1000, 17'h10001, 17'h0F200, 2'h2, 2'h2, 6'h24},
        '{16'h6084, 3'h2, 16'h1000, 17'h10004, 17'h10002, 2'h0, 2'h1, 6'h24}};

    oad_addr_engine uut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_rd_ack(mem_rd_ack), .busy(busy),
        .done(done));
    oad_mem_model mem (.pclk(pclk), .presetn(presetn), .lat(lat),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_rd_ack(mem_rd_ack));

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until pready, then lets one edge pass
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run(input logic [15:0] ins, input logic poke);
        apb(1'b1, `OAD_STATUS_OFS, 32'h2);
        apb(1'b1, `OAD_INSTR_OFS, {16'h0, ins});
        apb(1'b1, `OAD_CTRL_OFS, 32'h1);
        if (poke) apb(1'b1, `OAD_INSTR_OFS, 32'hFFFF);
        while (done !== 1'b1) @(posedge pclk);
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, counters, timeout
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (mem_rd_req && mem_rd_ack) n_reads++;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            close_out();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce  = 1'b1;
        lat = 8'h3;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OAD_INSTR_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, 8'h2C, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        foreach (tbl[i]) begin
            c = tbl[i];
            lat <= (i % 2 == 0) ? 8'h0 : 8'h3;
            apb(1'b1, 8'h3C, 32'h0200);
            apb(1'b1, 8'h20 + {3'h0, c.rn, 2'h0},
                (c.rn == 3'h7) ? 32'h0200 : 32'h1000);
            base = n_reads;
            run(c.ins, 1'b0);
            chk(32'(n_reads - base), {30'h0, c.rds});
            apb(1'b0, `OAD_DST_EA_OFS, 32'h0);
            chk(rd & 32'h1FFFF, {15'h0, c.dea});
            apb(1'b0, 8'h20 + {3'h0, c.rn, 2'h0}, 32'h0);
            chk(rd, {16'h0, c.raft});
            apb(1'b0, 8'h3C, 32'h0);
            chk(rd, (c.wc == 2'h2) ? 32'h0202 : 32'h0200);
            apb(1'b0, `OAD_STATUS_OFS, 32'h0);
            chk(rd & 32'h306, {22'h0, c.wc, 8'h2});
            apb(1'b0, `OAD_OPINFO_OFS, 32'h0);
            chk(rd & 32'h37, {26'h0, c.opi});
            chk(rd[13:8], c.ins[5:0]);
            if (c.opi[5]) begin
                chk(rd[19:14], c.ins[11:6]);
                apb(1'b0, `OAD_SRC_EA_OFS, 32'h0);
                chk(rd & 32'h1FFFF, {15'h0, c.sea});
            end
        end
        // slow memory; an instruction write while busy is dropped
        lat <= 8'h14;
        apb(1'b1, 8'h30, 32'h1000);
        run(16'h0A34, 1'b1);
        apb(1'b0, `OAD_INSTR_OFS, 32'h0);
        chk(rd, 32'h0A34);
        base = n_reads;
        run(16'h0000, 1'b0);
        apb(1'b0, `OAD_STATUS_OFS, 32'h0);
        chk(rd & 32'h6, 32'h6);
        chk(32'(n_reads - base), 32'h0);
        apb(1'b1, `OAD_STATUS_OFS, 32'h2);
        apb(1'b0, `OAD_STATUS_OFS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        // a frozen block must hold off every transfer
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, pready}, 32'h0);
        ce <= 1'b1;
        close_out();
    end
endmodule // tb_top
`default_nettype wire
